// ### hdl/sgfc_map.svh
// register offsets, field positions and reset values of the forwarding control bank
`ifndef SGFC_MAP_SVH
`define SGFC_MAP_SVH

// register indices; the byte address is four times the index
`define SGFC_IDX_FRAME_CHECK 8'h04
`define SGFC_IDX_FWD_MODE 8'h05
`define SGFC_IDX_HOST_LINK 8'h06

// frame_check_control fields
`define SGFC_BIT_HUGE 2
`define SGFC_BIT_SIZE_CHECK_OFF 1
`define SGFC_MASK_FRAME_CHECK 8'h06
`define SGFC_RST_FRAME_CHECK 8'h00

// forwarding_mode_control fields
`define SGFC_BIT_VLAN_EN 7
`define SGFC_BIT_IGMP_SNOOP 6
`define SGFC_BIT_DIRECT 5
`define SGFC_BIT_PRETAG 4
`define SGFC_BIT_TAG_MASK 1
`define SGFC_BIT_MIRROR_AND 0
`define SGFC_MASK_FWD_MODE 8'hF3
`define SGFC_RST_FWD_MODE 8'h00

// host_port_link_control fields
`define SGFC_BIT_BACK_PRESSURE 7
`define SGFC_BIT_HALF_DUPLEX 6
`define SGFC_MASK_HOST_LINK 8'hC0
`define SGFC_RST_HOST_LINK 8'h00

// frame length limits in bytes
`define SGFC_LEN_HUGE 11'h77c
`define SGFC_LEN_RELAXED 11'h600
`define SGFC_LEN_TAGGED 11'h5f2
`define SGFC_LEN_UNTAGGED 11'h5ee

`endif

// ### hdl/sgfc_pkg.sv
// types shared by the forwarding control bank
package sgfc_pkg;
	typedef logic [7:0] sgfc_byte_t;
	typedef logic [10:0] sgfc_len_t;
	typedef logic [4:0] sgfc_ports_t;
	typedef logic [2:0] sgfc_port_id_t;
endpackage

// ### hdl/sgfc_frame_policy.sv
// per-frame decisions drawn from the latched control fields
`timescale 1ns/10ps
`include "sgfc_map.svh"
module sgfc_frame_policy (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic frame_start,
	input wire sgfc_pkg::sgfc_byte_t frame_check,
	input wire sgfc_pkg::sgfc_byte_t fwd_mode,
	input wire sgfc_pkg::sgfc_len_t frame_len,
	input wire logic frame_tagged,
	input wire logic frame_special_tag,
	input wire sgfc_pkg::sgfc_ports_t vlan_identifier_low,
	input wire sgfc_pkg::sgfc_ports_t lookup_ports,
	input wire logic mirror_src_hit,
	input wire logic mirror_dst_hit,
	output logic drop,
	output sgfc_pkg::sgfc_ports_t dest_ports,
	output logic mirror
);
	import sgfc_pkg::*;

	sgfc_byte_t chk;
	sgfc_byte_t mode;
	sgfc_len_t limit;

	// ----------------------------------------
	// snapshot at frame start
	// ----------------------------------------
	// R16 - applies from next frame
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			chk <= `SGFC_RST_FRAME_CHECK;
			mode <= `SGFC_RST_FWD_MODE;
		end else if (frame_start) begin
			chk <= frame_check;
			mode <= fwd_mode;
		end
	end

	// ----------------------------------------
	// size limit
	// ----------------------------------------
	always_comb begin
		// R03 - huge overrides check
		if (chk[`SGFC_BIT_HUGE]) begin
			limit = `SGFC_LEN_HUGE;
		// R01 - relaxed size limit
		end else if (chk[`SGFC_BIT_SIZE_CHECK_OFF]) begin
			limit = `SGFC_LEN_RELAXED;
		// R02 - special tag exempt
		end else if (frame_tagged && frame_special_tag) begin
			limit = `SGFC_LEN_RELAXED;
		end else if (frame_tagged) begin
			limit = `SGFC_LEN_TAGGED;
		end else begin
			limit = `SGFC_LEN_UNTAGGED;
		end
	end

	// ----------------------------------------
	// registered decisions
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			drop <= 1'b0;
			dest_ports <= 5'h0_0;
			mirror <= 1'b0;
		end else begin
			// R01 - drop oversize frames
			drop <= frame_len > limit;
			// R09 - tag mask bitmap
			// R10 - only without vlan mode
			if (mode[`SGFC_BIT_TAG_MASK] && !mode[`SGFC_BIT_VLAN_EN] && frame_tagged) begin
				dest_ports <= vlan_identifier_low;
			end else begin
				dest_ports <= lookup_ports;
			end
			// R11 - mirror and/or match
			if (mode[`SGFC_BIT_MIRROR_AND]) begin
				mirror <= mirror_src_hit && mirror_dst_hit;
			end else begin
				mirror <= mirror_src_hit || mirror_dst_hit;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_mask_selects_ports: assert property (@(posedge clock) disable iff (!rst_n) // R09
		mode[`SGFC_BIT_TAG_MASK] && !mode[`SGFC_BIT_VLAN_EN] && frame_tagged
		|=> dest_ports == $past(vlan_identifier_low))
		else $error("tag mask did not pick ports");

	a_vlan_blocks_mask: assert property (@(posedge clock) disable iff (!rst_n) // R10
		mode[`SGFC_BIT_VLAN_EN] |=> dest_ports == $past(lookup_ports))
		else $error("tag mask used in vlan mode");

	a_huge_frame_kept: assert property (@(posedge clock) disable iff (!rst_n) // R03
		chk[`SGFC_BIT_HUGE] && frame_len == `SGFC_LEN_HUGE |=> !drop)
		else $error("huge frame dropped");

	a_special_tag_kept: assert property (@(posedge clock) disable iff (!rst_n) // R02
		chk == 8'h00 && frame_tagged && frame_special_tag && frame_len == `SGFC_LEN_RELAXED |=> !drop)
		else $error("special tagged frame dropped");
endmodule

// ### hdl/sgfc_top.sv
// apb register bank for global forwarding control of the switch
// Notes on behaviour
// R01 - with the size check bit set frames up to 1536 bytes pass, else tagged over 1522 and untagged over 1518 drop.
// R02 - tagged frames from the host carrying the special tag type id escape the tagged length limit.
// R03 - the huge frame bit allows frames to 1916 bytes and overrides the size check bit.
// R04 - vlan enable bit 7 of offset 0x05 turns on 802.1q forwarding and resets to zero.
// R05 - software fills the vlan table before it sets the vlan enable bit.
// R06 - igmp snoop bit 6 sends every igmp packet to the host side mac port.
// R07 - direct mode bit 5 forwards host port frames by the host's preamble prefix, bypassing lookup.
// R08 - pre-tag bit 4 puts the source port number into the preamble of frames sent to the host port.
// R09 - tag mask bit 1 uses the low five vlan identifier bits as the destination port bitmap.
// R10 - tag mask forwarding works only while vlan mode is off.
// R11 - mirror match bit 0 needs both ports to match when set and either when clear, reset zero.
// R12 - software picks the either-port mirror mode to mirror receive traffic only.
// R13 - bit 7 of offset 0x06 enables half duplex back pressure on the host port.
// R14 - bit 6 of offset 0x06 picks half duplex, reset from the receive bit 2 strap.
// R15 - reserved bits read zero and ignore writes.
// R16 - drop, ports and mirror use control values from the next frame start; the control outputs follow two clocks after the write.
`timescale 1ns/10ps
`include "sgfc_map.svh"
module sgfc_top (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic host_rx_bit2_strap_pin,
	input wire logic frame_start,
	input wire sgfc_pkg::sgfc_len_t frame_len,
	input wire logic frame_tagged,
	input wire logic frame_special_tag,
	input wire sgfc_pkg::sgfc_ports_t vlan_identifier_low,
	input wire sgfc_pkg::sgfc_ports_t lookup_ports,
	input wire logic mirror_src_hit,
	input wire logic mirror_dst_hit,
	output logic frame_drop,
	output sgfc_pkg::sgfc_ports_t frame_dest_ports,
	output logic frame_mirror,
	output logic vlan_enable,
	output logic igmp_snoop_enable,
	output logic direct_mode,
	output logic pretag_enable,
	output logic back_pressure_enable,
	output logic half_duplex
);
	import sgfc_pkg::*;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic [1:0] reg_sel(input logic [31:0] addr);
		logic [1:0] sel;
		sel = 2'h3;
		if (addr[1:0] == 2'h0 && addr[31:10] == 22'h0) begin
			case (addr[9:2])
				`SGFC_IDX_FRAME_CHECK: sel = 2'h0;
				`SGFC_IDX_FWD_MODE: sel = 2'h1;
				`SGFC_IDX_HOST_LINK: sel = 2'h2;
				default: sel = 2'h3;
			endcase
		end
		return sel;
	endfunction

	logic [1:0] sel;
	logic access;
	logic wr_ok;
	assign sel = reg_sel(paddr);
	assign access = psel && penable && !pready;
	assign wr_ok = access && pwrite && pstrb[0];

	// ----------------------------------------
	// registers
	// ----------------------------------------
	sgfc_byte_t frame_check;
	sgfc_byte_t fwd_mode;
	sgfc_byte_t host_link;
	logic strap_taken;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			frame_check <= `SGFC_RST_FRAME_CHECK;
		// R15 - reserved bits masked
		end else if (wr_ok && sel == 2'h0) begin
			frame_check <= pwdata[7:0] & `SGFC_MASK_FRAME_CHECK;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			// R04 - vlan off at reset
			// R11 - or match at reset
			fwd_mode <= `SGFC_RST_FWD_MODE;
		// R15 - reserved bits masked
		end else if (wr_ok && sel == 2'h1) begin
			fwd_mode <= pwdata[7:0] & `SGFC_MASK_FWD_MODE;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			host_link <= `SGFC_RST_HOST_LINK;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			// R14 - strap sets duplex
			strap_taken <= 1'b1;
			host_link <= {1'b0, host_rx_bit2_strap_pin, 6'h0_0};
		// R15 - reserved bits masked
		end else if (wr_ok && sel == 2'h2) begin
			host_link <= pwdata[7:0] & `SGFC_MASK_HOST_LINK;
		end
	end

	// ----------------------------------------
	// apb answer
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= access;
			pslverr <= access && sel == 2'h3;
			if (access && !pwrite) begin
				case (sel)
					2'h0: prdata <= {24'h00_0000, frame_check};
					2'h1: prdata <= {24'h00_0000, fwd_mode};
					2'h2: prdata <= {24'h00_0000, host_link};
					default: prdata <= 32'h0000_0000;
				endcase
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------
	// control outputs
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			vlan_enable <= 1'b0;
			igmp_snoop_enable <= 1'b0;
			direct_mode <= 1'b0;
			pretag_enable <= 1'b0;
			back_pressure_enable <= 1'b0;
			half_duplex <= 1'b0;
		end else begin
			// R04 - vlan forwarding on
			vlan_enable <= fwd_mode[`SGFC_BIT_VLAN_EN];
			// R06 - igmp to host port
			igmp_snoop_enable <= fwd_mode[`SGFC_BIT_IGMP_SNOOP];
			// R07 - direct prefix forwarding
			direct_mode <= fwd_mode[`SGFC_BIT_DIRECT];
			// R08 - source port pretag
			pretag_enable <= fwd_mode[`SGFC_BIT_PRETAG];
			// R13 - host back pressure
			back_pressure_enable <= host_link[`SGFC_BIT_BACK_PRESSURE];
			// R14 - host duplex mode
			half_duplex <= host_link[`SGFC_BIT_HALF_DUPLEX];
		end
	end

	// ----------------------------------------
	// frame decisions
	// ----------------------------------------
	sgfc_frame_policy u_policy (
		.clock(clock),
		.rst_n(rst_n),
		.frame_start(frame_start),
		.frame_check(frame_check),
		.fwd_mode(fwd_mode),
		.frame_len(frame_len),
		.frame_tagged(frame_tagged),
		.frame_special_tag(frame_special_tag),
		.vlan_identifier_low(vlan_identifier_low),
		.lookup_ports(lookup_ports),
		.mirror_src_hit(mirror_src_hit),
		.mirror_dst_hit(mirror_dst_hit),
		.drop(frame_drop),
		.dest_ports(frame_dest_ports),
		.mirror(frame_mirror)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_fwd_write;
		wr_ok && sel == 2'h1;
	endsequence

	a_vlan_follows_write: assert property (@(posedge clock) disable iff (!rst_n) // R04
		s_fwd_write ##2 1'b1 |-> vlan_enable == $past(pwdata[`SGFC_BIT_VLAN_EN], 2))
		else $error("vlan enable did not follow write");

	a_igmp_follows_reg: assert property (@(posedge clock) disable iff (!rst_n) // R06
		igmp_snoop_enable == $past(fwd_mode[`SGFC_BIT_IGMP_SNOOP]))
		else $error("igmp snoop output wrong");

	a_direct_follows_reg: assert property (@(posedge clock) disable iff (!rst_n) // R07
		direct_mode == $past(fwd_mode[`SGFC_BIT_DIRECT]))
		else $error("direct mode output wrong");

	a_pretag_follows_reg: assert property (@(posedge clock) disable iff (!rst_n) // R08
		pretag_enable == $past(fwd_mode[`SGFC_BIT_PRETAG]))
		else $error("pretag output wrong");

	a_backpress_follows_reg: assert property (@(posedge clock) disable iff (!rst_n) // R13
		back_pressure_enable == $past(host_link[`SGFC_BIT_BACK_PRESSURE]))
		else $error("back pressure output wrong");

	a_duplex_follows_reg: assert property (@(posedge clock) disable iff (!rst_n) // R14
		strap_taken && $past(strap_taken) |-> half_duplex == $past(host_link[`SGFC_BIT_HALF_DUPLEX]))
		else $error("duplex output wrong");

	a_reserved_read_zero: assert property (@(posedge clock) disable iff (!rst_n) // R15
		(fwd_mode & ~`SGFC_MASK_FWD_MODE) == 8'h00 && (frame_check & ~`SGFC_MASK_FRAME_CHECK) == 8'h00
		&& (host_link & ~`SGFC_MASK_HOST_LINK) == 8'h00)
		else $error("reserved bit set");

	sequence s_plain_snapshot;
		frame_start && frame_check == 8'h00 ##1 !frame_start && !frame_tagged && frame_len == 11'h5ef;
	endsequence

	a_oversize_untagged_drop: assert property (@(posedge clock) disable iff (!rst_n) // R01
		s_plain_snapshot |=> frame_drop)
		else $error("untagged oversize frame not dropped");

	a_mirror_and_mode: assert property (@(posedge clock) disable iff (!rst_n) // R11
		fwd_mode[`SGFC_BIT_MIRROR_AND] && frame_start ##1 (mirror_src_hit && !mirror_dst_hit) |=> !frame_mirror)
		else $error("and-mode mirror fired on one match");

	a_pready_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
		psel && penable |-> ##[0:1] pready)
		else $error("apb answer late");

	// ----------------------------------------
	// bus answer checks
	// ----------------------------------------
	sequence s_setup_phase;
		psel && !penable;
	endsequence

	sequence s_access_wait;
		psel && penable && !pready;
	endsequence

	a_apb_one_wait: assert property (@(posedge clock) disable iff (!rst_n)
		s_setup_phase ##1 s_access_wait |=> pready)
		else $error("apb wait state count wrong");

	a_answer_after_access: assert property (@(posedge clock) disable iff (!rst_n)
		pready |-> $past(psel) && $past(penable))
		else $error("apb answer without access");

	a_error_reads_zero: assert property (@(posedge clock) disable iff (!rst_n) // R15
		access && sel == 2'h3 |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access answered wrong");

	a_mapped_no_error: assert property (@(posedge clock) disable iff (!rst_n) // R15
		access && sel != 2'h3 |=> !pslverr)
		else $error("mapped access flagged error");

	a_upper_bits_zero: assert property (@(posedge clock) disable iff (!rst_n) // R15
		pready |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");

	a_error_with_ready: assert property (@(posedge clock) disable iff (!rst_n) // R15
		pslverr |-> pready)
		else $error("error flag outside answer");

	// ----------------------------------------
	// register checks
	// ----------------------------------------
	sequence s_link_write;
		wr_ok && sel == 2'h2 && strap_taken;
	endsequence

	a_unmapped_no_write: assert property (@(posedge clock) disable iff (!rst_n) // R15
		access && pwrite && sel == 2'h3 && strap_taken
		|=> $stable(frame_check) && $stable(fwd_mode) && $stable(host_link))
		else $error("unmapped write changed a register");

	a_strobe_no_write: assert property (@(posedge clock) disable iff (!rst_n) // R15
		access && pwrite && !pstrb[0] && strap_taken
		|=> $stable(frame_check) && $stable(fwd_mode) && $stable(host_link))
		else $error("write without low strobe landed");

	a_check_read_back: assert property (@(posedge clock) disable iff (!rst_n) // R03
		access && !pwrite && sel == 2'h0 |=> prdata[7:0] == $past(frame_check))
		else $error("frame check read back wrong");

	a_fwd_read_back: assert property (@(posedge clock) disable iff (!rst_n) // R04
		access && !pwrite && sel == 2'h1 |=> prdata[7:0] == $past(fwd_mode))
		else $error("forwarding mode read back wrong");

	a_link_read_back: assert property (@(posedge clock) disable iff (!rst_n) // R14
		access && !pwrite && sel == 2'h2 |=> prdata[7:0] == $past(host_link))
		else $error("host link read back wrong");

	a_huge_write_lands: assert property (@(posedge clock) disable iff (!rst_n) // R03
		wr_ok && sel == 2'h0 |=> frame_check[`SGFC_BIT_HUGE] == $past(pwdata[`SGFC_BIT_HUGE]))
		else $error("huge frame bit not written");

	a_tag_mask_write: assert property (@(posedge clock) disable iff (!rst_n) // R09
		s_fwd_write |=> fwd_mode[`SGFC_BIT_TAG_MASK] == $past(pwdata[`SGFC_BIT_TAG_MASK]))
		else $error("tag mask bit not written");

	a_backpress_follows_write: assert property (@(posedge clock) disable iff (!rst_n) // R13
		s_link_write ##2 1'b1 |-> back_pressure_enable == $past(pwdata[`SGFC_BIT_BACK_PRESSURE], 2))
		else $error("back pressure did not follow write");

	a_duplex_follows_write: assert property (@(posedge clock) disable iff (!rst_n) // R14
		s_link_write ##2 1'b1 |-> half_duplex == $past(pwdata[`SGFC_BIT_HALF_DUPLEX], 2))
		else $error("duplex did not follow write");

	a_strap_capture: assert property (@(posedge clock) disable iff (!rst_n) // R14
		$rose(strap_taken) |-> host_link == {1'b0, $past(host_rx_bit2_strap_pin), 6'h00})
		else $error("strap not captured into duplex bit");

	a_reset_two_stage: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(rst_n) |-> $past(rst_meta))
		else $error("reset released without first stage");
endmodule

// ### verification/sgfc_top_test.sv
// self-checking bench for the forwarding control register bank
`timescale 1ns/10ps
`include "sgfc_map.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module sgfc_top_test;
import sgfc_pkg::*;
logic clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, host_rx_bit2_strap_pin = 0;
logic [31:0] paddr = 0, pwdata = 0, prdata;
logic [3:0] pstrb = 0;
logic pready, pslverr, frame_start = 0, frame_tagged = 0, frame_special_tag = 0;
logic mirror_src_hit = 0, mirror_dst_hit = 0, frame_drop, frame_mirror, vlan_enable, igmp_snoop_enable;
logic direct_mode, pretag_enable, back_pressure_enable, half_duplex;
sgfc_len_t frame_len = 0;
sgfc_ports_t vlan_identifier_low = 0, lookup_ports = 0, frame_dest_ports;
int fail_count = 0, comparisons = 0;
logic [15:0] seed = 16'h543a;
sgfc_byte_t mdl [3];
sgfc_byte_t snap_fc, snap_fm;
logic [31:0] rd;
logic er;
sgfc_len_t lens [8] = '{11'd1518, 11'd1519, 11'd1522, 11'd1523, 11'd1536, 11'd1537, 11'd1916, 11'd1917};
always #2.5 clock = ~clock;
sgfc_top i_sgfc_top (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.host_rx_bit2_strap_pin(host_rx_bit2_strap_pin), .frame_start(frame_start), .frame_len(frame_len),
	.frame_tagged(frame_tagged), .frame_special_tag(frame_special_tag),
	.vlan_identifier_low(vlan_identifier_low), .lookup_ports(lookup_ports), .mirror_src_hit(mirror_src_hit),
	.mirror_dst_hit(mirror_dst_hit), .frame_drop(frame_drop), .frame_dest_ports(frame_dest_ports),
	.frame_mirror(frame_mirror), .vlan_enable(vlan_enable), .igmp_snoop_enable(igmp_snoop_enable),
	.direct_mode(direct_mode), .pretag_enable(pretag_enable), .back_pressure_enable(back_pressure_enable),
	.half_duplex(half_duplex));
// ----------------------------------------
// helpers
// ----------------------------------------
function automatic logic [15:0] rnd();
	seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
	return seed;
endfunction
function automatic sgfc_byte_t msk(input int k);
	return (k == 0) ? `SGFC_MASK_FRAME_CHECK : (k == 1) ? `SGFC_MASK_FWD_MODE : `SGFC_MASK_HOST_LINK;
endfunction
function automatic logic exp_drop(input sgfc_byte_t fc, input sgfc_len_t len, input logic tg, input logic sp);
	sgfc_len_t lim;
	if (fc[`SGFC_BIT_HUGE]) lim = `SGFC_LEN_HUGE;
	else if (fc[`SGFC_BIT_SIZE_CHECK_OFF] || (tg && sp)) lim = `SGFC_LEN_RELAXED;
	else if (tg) lim = `SGFC_LEN_TAGGED;
	else lim = `SGFC_LEN_UNTAGGED;
	return len > lim;
endfunction
task tally_and_finish;
	$display("comparisons %0d fail_count %0d", comparisons, fail_count);
	if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
	else $display("*** FAIL ***");
	$finish;
endtask
task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
	int n;
	@(posedge clock);
	psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
	@(posedge clock);
	penable <= 1;
	n = 0;
	do begin
		@(posedge clock);
		n++;
	end while (pready !== 1'b1 && n < 20);
	rd = prdata;
	er = pslverr;
	psel <= 0; penable <= 0;
	if (n >= 20) begin
		fail_count++;
		tally_and_finish;
	end
endtask
task automatic wr(input int k, input sgfc_byte_t d, input logic [3:0] s);
	apb(1, 32'(k + 4) << 2, {24'h0, d}, s);
	if (s[0]) mdl[k] = d & msk(k);
endtask
task automatic rd_chk(input int k);
	apb(0, 32'(k + 4) << 2, 0, 4'hf);
	`CHK("register", {24'h0, mdl[k]}, rd)
	`CHK("pslverr", 1'b0, er)
endtask
task automatic chk_out;
	@(posedge clock);
	#1;
	`CHK("vlan_enable", mdl[1][7], vlan_enable)
	`CHK("igmp", mdl[1][6], igmp_snoop_enable)
	`CHK("direct", mdl[1][5], direct_mode)
	`CHK("pretag", mdl[1][4], pretag_enable)
	`CHK("back_pressure", mdl[2][7], back_pressure_enable)
	`CHK("half_duplex", mdl[2][6], half_duplex)
endtask
task automatic do_reset(input logic sp);
	@(posedge clock);
	arst_n <= 0; host_rx_bit2_strap_pin <= sp;
	repeat (10) @(posedge clock);
	arst_n <= 1;
	repeat (6) @(posedge clock);
	mdl[0] = `SGFC_RST_FRAME_CHECK; mdl[1] = `SGFC_RST_FWD_MODE; mdl[2] = `SGFC_RST_HOST_LINK;
	mdl[2][6] = sp;
endtask
task automatic drive_frame(input logic st, input sgfc_len_t len);
	logic [15:0] r;
	r = rnd();
	@(posedge clock);
	frame_start <= st; frame_len <= len; frame_tagged <= r[0]; frame_special_tag <= r[1];
	vlan_identifier_low <= r[6:2]; lookup_ports <= r[11:7]; mirror_src_hit <= r[12]; mirror_dst_hit <= r[13];
	if (st) begin
		snap_fc = mdl[0];
		snap_fm = mdl[1];
	end
	@(posedge clock);
	frame_start <= 0;
	@(posedge clock);
	#1;
	`CHK("frame_drop", exp_drop(snap_fc, len, r[0], r[1]), frame_drop)
	`CHK("dest", (snap_fm[1] && !snap_fm[7] && r[0]) ? r[6:2] : r[11:7], frame_dest_ports)
	`CHK("mirror", snap_fm[0] ? (r[12] & r[13]) : (r[12] | r[13]), frame_mirror)
endtask
// ----------------------------------------
// main sequence
// ----------------------------------------
initial begin
	do_reset(0);
	for (int k = 0; k < 3; k++) rd_chk(k);
	chk_out;
	apb(0, 32'h0000_001c, 0, 4'hf);
	`CHK("unmapped_err", 1'b1, er)
	`CHK("unmapped_data", 32'h0000_0000, rd)
	apb(1, 32'h0000_0015, 32'h0000_00ff, 4'hf);
	`CHK("misaligned_err", 1'b1, er)
	rd_chk(1);
	for (int i = 0; i < 30; i++) begin
		wr(i % 3, sgfc_byte_t'(rnd()), (i % 5 == 4) ? 4'he : 4'hf);
		rd_chk(i % 3);
		chk_out;
	end
	for (int i = 0; i < 64; i++) begin
		if (i % 4 == 0) begin
			wr(0, sgfc_byte_t'(rnd()), 4'hf);
			wr(1, sgfc_byte_t'(rnd()), 4'hf);
		end
		drive_frame(1, (i % 3 == 2) ? sgfc_len_t'(rnd()) : lens[i % 8]);
	end
	// new values wait for the next frame start
	wr(0, 8'h00, 4'hf);
	wr(1, 8'h02, 4'hf);
	drive_frame(1, 11'd1530);
	wr(0, 8'h04, 4'hf);
	wr(1, 8'h81, 4'hf);
	drive_frame(0, 11'd1530);
	drive_frame(1, 11'd1530);
	do_reset(1);
	for (int k = 0; k < 3; k++) rd_chk(k);
	chk_out;
	tally_and_finish;
end
endmodule
